// ---- inc/pps_pkg.sv ----
// How it works
// - One output selection register per pin
// - Direction control keeps governing pin driver enable
// - Sync USART or I2C overrides driver enable
// - Same code table decoded on every pin
// - Six-bit output selection code
// - Signal reaches only its permitted ports
// - Lock flag freezes all selections
// - Flag changes only after 0x55, 0xAA
// - One-shot option comes from fuse input
// - With fuse, lock settable once, never cleared
// - Selection writes ignored while locked
// - Selection reads always return contents
// - Without fuse, each change needs fresh unlock
// - Sleep leaves selections untouched
// - Power-on reset restores default selections
// - Other resets keep selections
// - Power-on reset clears one-shot usage
// - Input code is port high, pin low
`default_nettype none
package pps_pkg;
  localparam int PPS_SEL_W = 6;
  localparam int PPS_NUM_CODES = 40;
  localparam int PPS_PINS_PER_PORT = 8;
  localparam int PPS_PORT_A = 0;
  localparam int PPS_PORT_B = 1;
  localparam int PPS_PORT_C = 2;
  localparam logic [5:0] PPS_CODE_LATCH = 6'h00;
  localparam logic [5:0] PPS_CODE_CLC1 = 6'h01;
  localparam logic [5:0] PPS_CODE_MOD = 6'h1A;
  localparam logic [5:0] PPS_CODE_CCP5 = 6'h27;
  localparam logic [5:0] PPS_OUT_SEL_RST = 6'h00;
  localparam logic [5:0] PPS_IN_SEL_RST = 6'h00;
  localparam logic [7:0] PPS_KEY_FIRST = 8'h55;
  localparam logic [7:0] PPS_KEY_SECOND = 8'hAA;
  localparam int PPS_LOCK_BIT = 0;
  localparam logic [11:0] PPS_OFS_LOCK = 12'h000;
  localparam logic [3:0] PPS_OFS_OUT_PAGE = 4'h1;
  localparam logic [3:0] PPS_OFS_IN_PAGE = 4'h2;
  localparam logic [2:0] PPS_ROUTE_ALL = 3'b111;
  localparam logic [2:0] PPS_ROUTE_AC = 3'b101;
  localparam logic [2:0] PPS_ROUTE_BC = 3'b110;
  localparam logic [2:0] PPS_ROUTE_C = 3'b100;
  localparam logic [2:0] PPS_ROUTE_NONE = 3'b000;

  typedef enum logic [1:0] {PPS_SEQ_IDLE, PPS_SEQ_GOT_FIRST, PPS_SEQ_ARMED} pps_seq_e;

  // Bit n set: code may drive a pin of port n (A, B, C)
  function automatic logic [2:0] pps_route(input logic [5:0] code);
    logic [2:0] r;
    r = PPS_ROUTE_NONE;
    if (code == PPS_CODE_LATCH) begin
      r = PPS_ROUTE_ALL;
    end else if (code == PPS_CODE_MOD) begin
      r = PPS_ROUTE_C;
    end else if (code == 6'h27 || code == 6'h24 || code == 6'h23 || code == 6'h22 || code == 6'h20 ||
                 code == 6'h1F || code == 6'h18 || code == 6'h12 || code == 6'h11 || code == 6'h02 ||
                 code == 6'h01) begin
      r = PPS_ROUTE_AC;
    end else if (code < 6'h28) begin
      r = PPS_ROUTE_BC;
    end
    return r;
  endfunction

  // Serial data/clock outputs whose peripheral may own the driver enable
  function automatic logic pps_ovr_capable(input logic [5:0] code);
    return code == 6'h26 || code == 6'h25 || code == 6'h16 || code == 6'h15 ||
           code == 6'h14 || code == 6'h13 || code == 6'h10 || code == 6'h0F;
  endfunction
endpackage
`default_nettype wire

// ---- logic/pps_pin_drv.sv ----
`timescale 1ns/10ps
`default_nettype none
module pps_pin_drv #(
  parameter int PORT_ID = 0,
  parameter int NUM_CODES = pps_pkg::PPS_NUM_CODES
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [5:0] sel_i,
  input wire logic latch_i,
  input wire logic dir_input_i,
  input wire logic [NUM_CODES-1:0] periph_out_i,
  input wire logic [NUM_CODES-1:0] periph_ovr_i,
  input wire logic [NUM_CODES-1:0] periph_oe_i,
  output logic pin_out_o,
  output logic pin_oe_o
);
  logic out_d;
  logic oe_d;
  logic out_q;
  logic oe_q;
  logic permitted;
  logic [2:0] route_ok;

  always_comb begin
    route_ok = pps_pkg::pps_route(sel_i);
    permitted = route_ok[PORT_ID] && (32'(sel_i) < NUM_CODES);
    out_d = 1'b0;
    oe_d = ~dir_input_i;
    if (sel_i == pps_pkg::PPS_CODE_LATCH) begin
      out_d = latch_i;
    end else if (permitted) begin
      out_d = periph_out_i[sel_i];
      if (pps_pkg::pps_ovr_capable(sel_i) && periph_ovr_i[sel_i]) begin
        oe_d = periph_oe_i[sel_i];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  assign pin_out_o = out_q;
  assign pin_oe_o = oe_q;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  route_block_a: assert property (sel_i == pps_pkg::PPS_CODE_MOD && PORT_ID != pps_pkg::PPS_PORT_C |=> !pin_out_o)
    else $error("modulator output leaked to a port other than C");
  drv_override_a: assert property (pps_pkg::pps_ovr_capable(sel_i) && permitted && periph_ovr_i[sel_i]
                                   |=> pin_oe_o == $past(periph_oe_i[sel_i]))
    else $error("serial peripheral did not take the driver enable");
  dir_control_a: assert property (sel_i == pps_pkg::PPS_CODE_CLC1 |=> pin_oe_o == !$past(dir_input_i))
    else $error("direction control lost the driver enable");
endmodule // pps_pin_drv
`default_nettype wire

// ---- logic/pps_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module pps_top #(
  parameter int NUM_PINS = 24,
  parameter int NUM_INPUTS = 8,
  parameter int NUM_CODES = pps_pkg::PPS_NUM_CODES
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic warm_reset_i,
  input wire logic one_shot_lock_fuse_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [NUM_PINS-1:0] port_latch_i,
  input wire logic [NUM_PINS-1:0] pin_direction_control_i,
  input wire logic [NUM_CODES-1:0] periph_out_i,
  input wire logic [NUM_CODES-1:0] periph_ovr_i,
  input wire logic [NUM_CODES-1:0] periph_oe_i,
  output logic [NUM_PINS-1:0] pin_out_o,
  output logic [NUM_PINS-1:0] pin_oe_o,
  output logic [NUM_INPUTS*6-1:0] in_sel_o,
  output logic selection_lock_flag_o
);
  logic [NUM_PINS-1:0][5:0] out_sel_q;
  logic [NUM_PINS-1:0][5:0] out_sel_d;
  logic [NUM_INPUTS-1:0][5:0] in_sel_q;
  logic [NUM_INPUTS-1:0][5:0] in_sel_d;
  pps_pkg::pps_seq_e seq_q;
  pps_pkg::pps_seq_e seq_d;
  logic lock_q;
  logic lock_d;
  logic used_q;
  logic used_d;
  logic fuse_q;
  logic fuse_d;
  logic fuse_valid_q;
  logic fuse_valid_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic [5:0] idx;
  logic hit_lock;
  logic hit_out;
  logic hit_in;
  logic wr_commit;
  logic rd_take;
  logic [7:0] wbyte;

  // Address decode; each register is one aligned word
  always_comb begin
    idx = paddr_i[7:2];
    hit_lock = paddr_i == pps_pkg::PPS_OFS_LOCK;
    hit_out = paddr_i[11:8] == pps_pkg::PPS_OFS_OUT_PAGE && paddr_i[1:0] == 2'b00 && 32'(idx) < NUM_PINS;
    hit_in = paddr_i[11:8] == pps_pkg::PPS_OFS_IN_PAGE && paddr_i[1:0] == 2'b00 && 32'(idx) < NUM_INPUTS;
    wr_commit = psel_i && penable_i && pwrite_i && pready_q;
    rd_take = psel_i && penable_i && !pready_q;
    wbyte = pwdata_i[7:0];
  end

  // Bus answer: one wait cycle, so read data and error are registered with ready
  always_comb begin
    pready_d = rd_take;
    pslverr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    if (rd_take) begin
      pslverr_d = !(hit_lock || hit_out || hit_in);
      if (!pwrite_i) begin
        if (hit_lock) begin
          prdata_d[pps_pkg::PPS_LOCK_BIT] = lock_q;
        end else if (hit_out) begin
          prdata_d[5:0] = out_sel_q[idx];
        end else if (hit_in) begin
          prdata_d[5:0] = in_sel_q[idx];
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // Fuse is a configuration bit: caught once after power-on release, then held
  always_comb begin
    fuse_d = fuse_q;
    fuse_valid_d = 1'b1;
    if (!fuse_valid_q) begin
      fuse_d = one_shot_lock_fuse_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fuse_q <= 1'b0;
      fuse_valid_q <= 1'b0;
    end else begin
      fuse_q <= fuse_d;
      fuse_valid_q <= fuse_valid_d;
    end
  end

  // Unlock tracker and lock flag; any intervening write other than a repeated 0x55 breaks the sequence
  always_comb begin
    seq_d = seq_q;
    lock_d = lock_q;
    used_d = used_q;
    if (wr_commit) begin
      if (hit_lock) begin
        unique case (seq_q)
          pps_pkg::PPS_SEQ_IDLE: begin
            seq_d = (wbyte == pps_pkg::PPS_KEY_FIRST) ? pps_pkg::PPS_SEQ_GOT_FIRST : pps_pkg::PPS_SEQ_IDLE;
          end
          pps_pkg::PPS_SEQ_GOT_FIRST: begin
            if (wbyte == pps_pkg::PPS_KEY_SECOND) begin
              seq_d = pps_pkg::PPS_SEQ_ARMED;
            end else if (wbyte == pps_pkg::PPS_KEY_FIRST) begin
              seq_d = pps_pkg::PPS_SEQ_GOT_FIRST;
            end else begin
              seq_d = pps_pkg::PPS_SEQ_IDLE;
            end
          end
          pps_pkg::PPS_SEQ_ARMED: begin
            seq_d = pps_pkg::PPS_SEQ_IDLE;
            if (!(fuse_q && used_q)) begin
              lock_d = pwdata_i[pps_pkg::PPS_LOCK_BIT];
              if (fuse_q && pwdata_i[pps_pkg::PPS_LOCK_BIT]) begin
                used_d = 1'b1;
              end
            end
          end
        endcase
      end else begin
        seq_d = pps_pkg::PPS_SEQ_IDLE;
      end
    end
    if (warm_reset_i) begin
      seq_d = pps_pkg::PPS_SEQ_IDLE;
    end
  end

  // Only power-on reset clears usage, so the one-shot lock survives warm resets
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      seq_q <= pps_pkg::PPS_SEQ_IDLE;
      lock_q <= 1'b0;
      used_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
      lock_q <= lock_d;
      used_q <= used_d;
    end
  end

  // Selections change only on an unlocked bus write; sleep and warm reset leave them alone
  always_comb begin
    out_sel_d = out_sel_q;
    in_sel_d = in_sel_q;
    if (wr_commit && !lock_q) begin
      if (hit_out) begin
        out_sel_d[idx] = pwdata_i[5:0];
      end
      if (hit_in) begin
        in_sel_d[idx] = pwdata_i[5:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_sel_q <= {NUM_PINS{pps_pkg::PPS_OUT_SEL_RST}};
      in_sel_q <= {NUM_INPUTS{pps_pkg::PPS_IN_SEL_RST}};
    end else begin
      out_sel_q <= out_sel_d;
      in_sel_q <= in_sel_d;
    end
  end

  // Pins A0..A7, B0..B7, C0..C7 in order; port decides what may be routed
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    pps_pin_drv #(
      .PORT_ID(p / pps_pkg::PPS_PINS_PER_PORT),
      .NUM_CODES(NUM_CODES)
    ) u_drv (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .sel_i(out_sel_q[p]),
      .latch_i(port_latch_i[p]),
      .dir_input_i(pin_direction_control_i[p]),
      .periph_out_i(periph_out_i),
      .periph_ovr_i(periph_ovr_i),
      .periph_oe_i(periph_oe_i),
      .pin_out_o(pin_out_o[p]),
      .pin_oe_o(pin_oe_o[p])
    );
  end

  assign in_sel_o = in_sel_q;
  assign selection_lock_flag_o = lock_q;
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sel_frozen_a: assert property (lock_q && wr_commit |=> $stable(out_sel_q) && $stable(in_sel_q))
    else $error("selection changed while locked");
  first_key_a: assert property (seq_q == pps_pkg::PPS_SEQ_IDLE && wr_commit && hit_lock &&
                                wbyte == pps_pkg::PPS_KEY_FIRST |=> seq_q == pps_pkg::PPS_SEQ_GOT_FIRST)
    else $error("first key not accepted");
  flag_armed_a: assert property ($changed(lock_q) |-> $past(seq_q) == pps_pkg::PPS_SEQ_ARMED)
    else $error("lock flag changed without unlock sequence");
  one_way_a: assert property (fuse_q && used_q && lock_q |=> lock_q)
    else $error("one-shot lock was cleared");
  seq_abort_a: assert property (seq_q == pps_pkg::PPS_SEQ_GOT_FIRST && wr_commit && hit_lock &&
                                wbyte != pps_pkg::PPS_KEY_FIRST && wbyte != pps_pkg::PPS_KEY_SECOND
                                |=> seq_q == pps_pkg::PPS_SEQ_IDLE)
    else $error("tracker kept state after a wrong key");
  rearm_needed_a: assert property (seq_q == pps_pkg::PPS_SEQ_ARMED && wr_commit && hit_lock
                                   |=> seq_q == pps_pkg::PPS_SEQ_IDLE ##1 $stable(lock_q))
    else $error("lock flag changed twice on one unlock");
  read_back_a: assert property (rd_take && !pwrite_i && hit_out
                                |=> pready_o && prdata_o[5:0] == $past(out_sel_q[idx]))
    else $error("selection read-back wrong");
  warm_keep_a: assert property (warm_reset_i && !wr_commit |=> $stable(out_sel_q) && $stable(in_sel_q))
    else $error("warm reset disturbed selections");
  unlocked_write_a: assert property (!lock_q && wr_commit && hit_out
                                     |=> out_sel_q[$past(idx)] == $past(pwdata_i[5:0]))
    else $error("unlocked selection write lost");
endmodule // pps_top
`default_nettype wire

// ---- verif/pps_periph_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module pps_periph_model #(
  parameter int NUM_CODES = 40
) (
  input wire logic ref_clk_i,
  input wire logic [NUM_CODES-1:0] level_i,
  input wire logic sync_mode_i,
  input wire logic drive_en_i,
  output logic [NUM_CODES-1:0] periph_out_o,
  output logic [NUM_CODES-1:0] periph_ovr_o,
  output logic [NUM_CODES-1:0] periph_oe_o
);
  // Only serial sync and I2C outputs ever claim the pin driver
  localparam logic [NUM_CODES-1:0] OVR_MASK = NUM_CODES'(40'h60_0079_8000);
  always_ff @(posedge ref_clk_i) begin
    periph_out_o <= level_i;
    periph_ovr_o <= sync_mode_i ? OVR_MASK : '0;
    periph_oe_o <= drive_en_i ? OVR_MASK : ~OVR_MASK;
  end
endmodule // pps_periph_model
`default_nettype wire

// ---- verif/pps_top_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module pps_top_tb;
  logic ref_clk_i = 0, reset_i = 1, warm_reset_i = 0, fuse = 0;
  logic psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rd;
  logic pready_o, pslverr_o, er, flag, sync = 0, drv = 0;
  logic [23:0] latch = '0, dir = '0, pin_out, pin_oe;
  logic [39:0] lvl = '1, p_out, p_ovr, p_oe;
  logic [47:0] in_sel;
  int n_mismatch = 0, checks_done = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  pps_periph_model model (.ref_clk_i(ref_clk_i), .level_i(lvl), .sync_mode_i(sync), .drive_en_i(drv),
    .periph_out_o(p_out), .periph_ovr_o(p_ovr), .periph_oe_o(p_oe));
  pps_top uut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .warm_reset_i(warm_reset_i),
    .one_shot_lock_fuse_i(fuse), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .port_latch_i(latch), .pin_direction_control_i(dir), .periph_out_i(p_out),
    .periph_ovr_i(p_ovr), .periph_oe_i(p_oe), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
    .in_sel_o(in_sel), .selection_lock_flag_o(flag));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Called right after a rising edge; returns one edge after release
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    rd = prdata_o;
    er = pslverr_o;
    if (pready_o !== 1'b1) chk(0, 1);
    psel_i <= 0;
    penable_i <= 0;
    @(posedge ref_clk_i);
  endtask
  // Key pair and flag write run back to back with nothing between
  task automatic unlock(input logic v);
    apb(1, 12'h000, 32'h0000_0055);
    apb(1, 12'h000, 32'h0000_00AA);
    apb(1, 12'h000, {31'h0, v});
  endtask
  task automatic por(input logic f);
    fuse <= f;
    reset_i <= 1;
    repeat (5) @(posedge ref_clk_i);
    reset_i <= 0;
    repeat (2) @(posedge ref_clk_i);
  endtask
  task automatic settle();
    repeat (3) @(posedge ref_clk_i);
  endtask
  task automatic t_reset();
    chk(flag, 0);
    chk(in_sel[31:0], 0);
    chk(32'(in_sel[47:32]), 0);
    apb(0, 12'h114, 0);
    chk(rd, 0);
    apb(0, 12'h300, 0);
    chk({rd[30:0], er}, 1);
  endtask
  task automatic t_route();
    int pin[8] = '{16, 0, 8, 1, 9, 10, 2, 23};
    logic [5:0] code[8] = '{6'h1A, 6'h1A, 6'h1A, 6'h27, 6'h27, 6'h25, 6'h01, 6'h28};
    logic exp[8] = '{1, 0, 0, 1, 0, 1, 1, 0};
    for (int i = 0; i < 8; i++) apb(1, 12'(12'h100 + 4 * pin[i]), {26'h0, code[i]});
    settle();
    for (int i = 0; i < 8; i++) begin
      chk(pin_out[pin[i]], exp[i]);
      chk(pin_oe[pin[i]], 1);
      apb(0, 12'(12'h100 + 4 * pin[i]), 0);
      chk(rd, {26'h0, code[i]});
    end
  endtask
  task automatic t_dir();
    dir[16] <= 1;
    latch[3] <= 1;
    settle();
    chk(pin_oe[16], 0);
    chk(pin_out[3], 1);
  endtask
  task automatic t_ovr();
    sync <= 1;
    settle();
    chk(pin_oe[10], 0);
    dir[10] <= 1;
    drv <= 1;
    settle();
    chk(pin_oe[10], 1);
    sync <= 0;
    settle();
    chk(pin_oe[10], 0);
  endtask
  task automatic t_lock();
    unlock(1);
    chk(flag, 1);
    apb(1, 12'h140, 32'h0000_0000);
    apb(1, 12'h200, 32'h0000_0017);
    apb(0, 12'h140, 0);
    chk(rd, 32'h0000_001A);
    chk(in_sel[31:0], 0);
    chk(32'(in_sel[47:32]), 0);
    apb(1, 12'h000, 32'h0000_0055);
    apb(1, 12'h104, 32'h0000_0000);
    apb(1, 12'h000, 32'h0000_00AA);
    apb(1, 12'h000, 32'h0000_0000);
    chk(flag, 1);
    apb(1, 12'h000, 32'h0000_0055);
    apb(1, 12'h000, 32'h0000_0012);
    apb(1, 12'h000, 32'h0000_00AA);
    apb(1, 12'h000, 32'h0000_0000);
    chk(flag, 1);
    unlock(0);
    chk(flag, 0);
    apb(1, 12'h200, 32'h0000_0017);
    apb(1, 12'h15C, 32'h0000_0026);
    settle();
    chk(in_sel[5:0], 6'h17);
    chk(pin_out[23], 1);
    unlock(1);
    chk(flag, 1);
  endtask
  task automatic t_warm();
    warm_reset_i <= 1;
    @(posedge ref_clk_i);
    warm_reset_i <= 0;
    settle();
    chk(flag, 1);
    chk(in_sel[5:0], 6'h17);
    apb(0, 12'h140, 0);
    chk(rd, 32'h0000_001A);
  endtask
  task automatic t_fuse();
    por(1);
    chk(flag, 0);
    chk(in_sel[31:0], 0);
    chk(32'(in_sel[47:32]), 0);
    apb(0, 12'h140, 0);
    chk(rd, 0);
    unlock(1);
    unlock(0);
    chk(flag, 1);
    por(1);
    unlock(1);
    chk(flag, 1);
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_i);
    reset_i <= 0;
    repeat (2) @(posedge ref_clk_i);
    t_reset();
    t_route();
    t_dir();
    t_ovr();
    t_lock();
    t_warm();
    t_fuse();
    final_report();
  end
  initial begin
    #100us;
    n_mismatch++;
    final_report();
  end
endmodule // pps_top_tb
`default_nettype wire
